/* vacs_pkg.sv */
// shared types and constants of the viterbi add-compare-select datapath
package vacs_pkg;

    // widths and field positions
    localparam int HALF_W = 16;
    localparam int WORD_W = 32;
    localparam int ACC_W = 40;
    localparam int HI_LSB = 16;
    localparam int WORD_MSB = 31;
    localparam int N_HALF = 2;

    // history shift per form
    localparam int DUAL_SHIFT = 2;
    localparam int SINGLE_SHIFT = 1;

    // reset values
    localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;
    localparam logic [WORD_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;

    // operations issued by the decoder
    typedef enum logic [2:0] {
        OP_ADD_SIGN,
        OP_DUAL_ASL,
        OP_DUAL_ASR,
        OP_SINGLE_ASL,
        OP_SINGLE_ASR
    } vacs_op_e;

    // request: operation and both source registers
    typedef struct packed {
        logic valid;
        vacs_op_e op;
        logic [WORD_W-1:0] src0;
        logic [WORD_W-1:0] src1;
    } vacs_req_s;

    // result toward the data register file
    typedef struct packed {
        logic valid;
        logic wr_hi;
        logic wr_lo;
        logic [WORD_W-1:0] data;
    } vacs_res_s;

    // whole state of the datapath
    typedef struct packed {
        vacs_res_s res;
        logic [ACC_W-1:0] acc;
        logic flags_we;
    } vacs_state_s;

endpackage : vacs_pkg

/* vacs_max16.sv */
// signed 16-bit maximum on the two's-complement circle
`timescale 1ns/10ps
module vacs_max16 (
    // the two halves to compare
    input wire logic [vacs_pkg::HALF_W-1:0] hi_i,
    input wire logic [vacs_pkg::HALF_W-1:0] lo_i,
    // selected maximum and decision
    output logic [vacs_pkg::HALF_W-1:0] max_o,
    output logic hi_won_o
);

    logic [vacs_pkg::HALF_W-1:0] diff;

    // wrapped difference keeps overflowed metrics ranked
    always_comb begin
        diff = vacs_pkg::HALF_W'(hi_i - lo_i); // RQ19
        // a tie or negative difference leaves the low half
        hi_won_o = !diff[vacs_pkg::HALF_W-1] && (diff != vacs_pkg::HALF_ZERO); // RQ20
        max_o = hi_won_o ? hi_i : lo_i;
    end

endmodule : vacs_max16

/* vacs_datapath.sv */
// sign-conditional add and compare-select datapath with history accumulator
`timescale 1ns/10ps

// Summary of operation
// RQ1: factor of plus/minus one from first-source sign
// RQ2: adjusted half keeps second-source magnitude
// RQ3: same 16-bit sum into both destination halves
// RQ4: sum wraps, never saturates
// RQ5: program uses one register per operand group
// RQ6: compare-select treats operands as signed
// RQ7: dual gives two maxima, single one low
// RQ8: upper from first source, lower from second
// RQ9: decisions shift into accumulator zero low word
// RQ10: program clears accumulator extension beforehand
// RQ11: dual left form shifts left by two
// RQ12: left form: upper bit second, lower first
// RQ13: dual right form shifts right by two
// RQ14: right form: top bit first, next second
// RQ15: second-source decision enters before the first
// RQ16: single left form shifts left by one
// RQ17: single right form shifts right by one
// RQ18: single decision is one when high wins
// RQ19: compare by sign of wrapped difference
// RQ20: ties select low half, decision zero
// RQ21: no arithmetic status flag changes
module vacs_datapath (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // operation from the decoder
    input wire vacs_pkg::vacs_req_s req_i,
    // accumulator zero load path
    input wire logic acc_load_i,
    input wire logic [vacs_pkg::ACC_W-1:0] acc_load_data_i,
    // results
    output vacs_pkg::vacs_res_s res_o,
    output logic [vacs_pkg::ACC_W-1:0] accum_zero_o,
    output logic flags_we_o
);

    localparam int HW = vacs_pkg::HALF_W;
    localparam int AW = vacs_pkg::ACC_W;

    vacs_pkg::vacs_state_s st;
    vacs_pkg::vacs_state_s next_st;

    logic [HW-1:0] adj [vacs_pkg::N_HALF];
    logic [HW-1:0] pmax [vacs_pkg::N_HALF];
    logic [vacs_pkg::N_HALF-1:0] hi_won;
    logic [HW-1:0] aos_sum;
    logic dy;
    logic dz;

    // per-half sign adjust and per-source maximum
    for (genvar g = 0; g < vacs_pkg::N_HALF; g++) begin : g_half
        logic [HW-1:0] a;
        logic [HW-1:0] b;
        logic [vacs_pkg::WORD_W-1:0] pick;

        assign a = req_i.src0[g*HW +: HW];
        assign b = req_i.src1[g*HW +: HW];
        // negate exactly when the first-source half is negative
        assign adj[g] = a[HW-1] ? HW'(vacs_pkg::HALF_ZERO - b) : b; // RQ1 RQ2

        // pair 0 compares the first source, pair 1 the second
        assign pick = (g == 0) ? req_i.src0 : req_i.src1;

        vacs_max16 u_max (
            .hi_i(pick[vacs_pkg::HI_LSB +: HW]),
            .lo_i(pick[HW-1:0]),
            .max_o(pmax[g]),
            .hi_won_o(hi_won[g])
        ); // RQ6 RQ19 RQ20
    end

    // wrapped sum, no saturation
    assign aos_sum = HW'(adj[1] + adj[0]); // RQ4
    assign dy = hi_won[0];
    assign dz = hi_won[1];

    // next-state logic
    always_comb begin
        logic [AW-1:0] shr;
        shr = '0;
        next_st = st;
        next_st.res.valid = 1'b0;
        next_st.res.wr_hi = 1'b0;
        next_st.res.wr_lo = 1'b0;
        // this datapath owns no status flag
        next_st.flags_we = 1'b0; // RQ21
        if (req_i.valid) begin
            unique case (req_i.op)
                vacs_pkg::OP_ADD_SIGN: begin
                    next_st.res.data = {aos_sum, aos_sum}; // RQ3
                    next_st.res.wr_hi = 1'b1;
                    next_st.res.wr_lo = 1'b1;
                    next_st.res.valid = 1'b1;
                end
                vacs_pkg::OP_DUAL_ASL: begin
                    next_st.res.data = {pmax[0], pmax[1]}; // RQ7 RQ8
                    next_st.res.wr_hi = 1'b1;
                    next_st.res.wr_lo = 1'b1;
                    next_st.res.valid = 1'b1;
                    // second-source bit goes in first, so it sits higher
                    next_st.acc = {st.acc[AW-1-vacs_pkg::DUAL_SHIFT:0], dz, dy}; // RQ11 RQ12 RQ15
                end
                vacs_pkg::OP_DUAL_ASR: begin
                    next_st.res.data = {pmax[0], pmax[1]}; // RQ7 RQ8
                    next_st.res.wr_hi = 1'b1;
                    next_st.res.wr_lo = 1'b1;
                    next_st.res.valid = 1'b1;
                    // first-source bit enters last, so it lands on top
                    shr = st.acc >> vacs_pkg::DUAL_SHIFT;
                    shr[vacs_pkg::WORD_MSB -: vacs_pkg::DUAL_SHIFT] = {dy, dz}; // RQ14 RQ15
                    next_st.acc = shr; // RQ9 RQ13
                end
                vacs_pkg::OP_SINGLE_ASL: begin
                    next_st.res.data[HW-1:0] = pmax[0]; // RQ7
                    next_st.res.wr_lo = 1'b1;
                    next_st.res.valid = 1'b1;
                    next_st.acc = {st.acc[AW-1-vacs_pkg::SINGLE_SHIFT:0], dy}; // RQ16 RQ18
                end
                vacs_pkg::OP_SINGLE_ASR: begin
                    next_st.res.data[HW-1:0] = pmax[0]; // RQ7
                    next_st.res.wr_lo = 1'b1;
                    next_st.res.valid = 1'b1;
                    shr = st.acc >> vacs_pkg::SINGLE_SHIFT;
                    shr[vacs_pkg::WORD_MSB] = dy; // RQ17 RQ18
                    next_st.acc = shr; // RQ9
                end
                default: begin
                    // illegal operation code: no result, no history
                    next_st.res.valid = 1'b0;
                end
            endcase
        end
        // an explicit load of accumulator zero overrides a shift
        if (acc_load_i) begin
            next_st.acc = acc_load_data_i;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st.res.valid <= 1'b0;
            st.res.wr_hi <= 1'b0;
            st.res.wr_lo <= 1'b0;
            st.res.data <= vacs_pkg::DATA_RST;
            st.acc <= vacs_pkg::ACC_RST;
            st.flags_we <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign res_o = st.res;
    assign accum_zero_o = st.acc;
    assign flags_we_o = st.flags_we;

    // checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // reference values built a different way from the datapath
    logic [HW-1:0] ref_b1;
    logic [HW-1:0] ref_b0;
    logic [HW-1:0] ref_sum;
    logic signed [HW:0] ref_m1;
    logic signed [HW:0] ref_m0;

    // multiply by the sign factor on a widened product
    always_comb begin
        ref_m1 = $signed(req_i.src0[31]) ? -$signed({1'b0, 16'h0001})
                                         : $signed({1'b0, 16'h0001});
        ref_m0 = $signed(req_i.src0[15]) ? -$signed({1'b0, 16'h0001})
                                         : $signed({1'b0, 16'h0001});
        ref_b1 = HW'($signed(req_i.src1[31:16]) * ref_m1);
        ref_b0 = HW'($signed(req_i.src1[15:0]) * ref_m0);
        ref_sum = HW'(ref_b1 + ref_b0);
    end

    // named steps of each operation
    sequence s_aos;
        req_i.valid && req_i.op == vacs_pkg::OP_ADD_SIGN;
    endsequence

    sequence s_dual_asl;
        req_i.valid && req_i.op == vacs_pkg::OP_DUAL_ASL && !acc_load_i;
    endsequence

    sequence s_dual_asr;
        req_i.valid && req_i.op == vacs_pkg::OP_DUAL_ASR && !acc_load_i;
    endsequence

    sequence s_single_asl;
        req_i.valid && req_i.op == vacs_pkg::OP_SINGLE_ASL && !acc_load_i;
    endsequence

    sequence s_single_asr;
        req_i.valid && req_i.op == vacs_pkg::OP_SINGLE_ASR && !acc_load_i;
    endsequence

    sequence s_single_any;
        req_i.valid && (req_i.op == vacs_pkg::OP_SINGLE_ASL ||
                        req_i.op == vacs_pkg::OP_SINGLE_ASR);
    endsequence

    sequence s_dual_any;
        req_i.valid && (req_i.op == vacs_pkg::OP_DUAL_ASL ||
                        req_i.op == vacs_pkg::OP_DUAL_ASR);
    endsequence

    // add on sign: product-based reference in both halves
    aos_sum_value_a: assert property ( // RQ1
        s_aos |=> res_o.data[15:0] == $past(ref_sum)
    ) else $error("add on sign sum wrong");

    aos_both_halves_a: assert property ( // RQ3
        s_aos |=> res_o.valid && res_o.wr_hi && res_o.wr_lo
                  && res_o.data[31:16] == res_o.data[15:0]
    ) else $error("add on sign halves differ");

    // wrap: two large positives must come back wrapped
    aos_wraps_a: assert property ( // RQ4
        (s_aos and (req_i.src0 == 32'h0000_0000 && req_i.src1 == 32'h7FFF_7FFF))
        |=> res_o.data[15:0] == 16'hFFFE
    ) else $error("add on sign saturated");

    // dual maxima placed by source
    cs_dual_max_a: assert property ( // RQ8
        s_dual_any |=> res_o.wr_hi && res_o.wr_lo
            && res_o.data[31:16] == ($past(dy) ? $past(req_i.src0[31:16])
                                               : $past(req_i.src0[15:0]))
            && res_o.data[15:0] == ($past(dz) ? $past(req_i.src1[31:16])
                                              : $past(req_i.src1[15:0]))
    ) else $error("dual maxima misplaced");

    // single form writes the low half only
    cs_single_low_a: assert property ( // RQ7
        s_single_any |=> res_o.valid && res_o.wr_lo && !res_o.wr_hi
    ) else $error("single form wrote high half");

    // wrapped comparison ranks an overflowed metric higher
    wrap_compare_a: assert property ( // RQ19
        (s_single_any and (req_i.src0 == 32'h8000_7FFF))
        |=> res_o.data[15:0] == 16'h8000
    ) else $error("wrapped compare wrong");

    // tie picks the low half and records zero
    tie_low_a: assert property ( // RQ20
        (s_single_asl and (req_i.src0[31:16] == req_i.src0[15:0]))
        |=> !accum_zero_o[0] && res_o.data[15:0] == $past(req_i.src0[15:0])
    ) else $error("tie not resolved to low half");

    // left dual: history moves up two, z bit above y bit
    hist_asl2_a: assert property ( // RQ11
        s_dual_asl |=> accum_zero_o[39:2] == $past(accum_zero_o[37:0])
            && accum_zero_o[1:0] == {$past(dz), $past(dy)}
    ) else $error("left dual history wrong");

    // right dual: history moves down two, y bit on top
    hist_asr2_a: assert property ( // RQ13
        s_dual_asr |=> accum_zero_o[29:0] == $past(accum_zero_o[31:2])
            && accum_zero_o[31:30] == {$past(dy), $past(dz)}
    ) else $error("right dual history wrong");

    // single left: one bit in at the bottom
    hist_asl1_a: assert property ( // RQ16
        s_single_asl |=> accum_zero_o[39:1] == $past(accum_zero_o[38:0])
            && accum_zero_o[0] == $past(dy)
    ) else $error("single left history wrong");

    // single right: one bit in at the top of the low word
    hist_asr1_a: assert property ( // RQ17
        s_single_asr |=> accum_zero_o[30:0] == $past(accum_zero_o[31:1])
            && accum_zero_o[31] == $past(dy)
    ) else $error("single right history wrong");

    // add on sign leaves the history alone
    aos_keeps_acc_a: assert property ( // RQ9
        (s_aos and !acc_load_i) |=> $stable(accum_zero_o)
    ) else $error("add on sign touched history");

    // result is a single-cycle pulse unless re-issued
    res_pulse_a: assert property ( // RQ7
        (res_o.valid && !$past(req_i.valid)) |-> 1'b0
    ) else $error("result without request");

    // status flags are never written
    flags_quiet_a: assert property ( // RQ21
        (req_i.valid ##1 1'b1) |-> !flags_we_o
    ) else $error("status flags written");

    // decisions judged again by signed difference, apart from the compare cells
    logic [HW-1:0] ref_dy_diff;
    logic [HW-1:0] ref_dz_diff;
    logic ref_dy;
    logic ref_dz;
    logic [HW-1:0] ref_max0;
    logic [HW-1:0] ref_max1;

    // a plain signed compare of the raw halves would misrank overflowed metrics
    always_comb begin
        ref_dy_diff = HW'(req_i.src0[vacs_pkg::HI_LSB +: HW] - req_i.src0[HW-1:0]);
        ref_dz_diff = HW'(req_i.src1[vacs_pkg::HI_LSB +: HW] - req_i.src1[HW-1:0]);
        ref_dy = $signed(ref_dy_diff) > $signed(vacs_pkg::HALF_ZERO);
        ref_dz = $signed(ref_dz_diff) > $signed(vacs_pkg::HALF_ZERO);
        ref_max0 = ref_dy ? req_i.src0[vacs_pkg::HI_LSB +: HW] : req_i.src0[HW-1:0];
        ref_max1 = ref_dz ? req_i.src1[vacs_pkg::HI_LSB +: HW] : req_i.src1[HW-1:0];
    end

    // an undefined operation code
    sequence s_illegal;
        req_i.valid && req_i.op > vacs_pkg::OP_SINGLE_ASR && !acc_load_i;
    endsequence

    // compare cells agree with the separate judgement
    decision_ref_a: assert property ( // RQ19
        req_i.valid |-> dy == ref_dy && dz == ref_dz
    ) else $error("decision bits disagree");

    // dual maxima against the separate judgement
    dual_max_ref_a: assert property ( // RQ8
        s_dual_any |=> res_o.data == {$past(ref_max0), $past(ref_max1)}
    ) else $error("dual maxima wrong");

    // history bits from the separate judgement
    hist_bits_asl2_a: assert property ( // RQ12
        s_dual_asl |=> accum_zero_o[1:0] == {$past(ref_dz), $past(ref_dy)}
    ) else $error("left dual history bits wrong");

    hist_bits_asr2_a: assert property ( // RQ14
        s_dual_asr |=> accum_zero_o[31:30] == {$past(ref_dy), $past(ref_dz)}
    ) else $error("right dual history bits wrong");

    // single decision bit, one when the high half wins
    single_bit_asl_a: assert property ( // RQ18
        s_single_asl |=> accum_zero_o[0] == $past(ref_dy)
    ) else $error("single left decision bit wrong");

    single_bit_asr_a: assert property ( // RQ18
        s_single_asr |=> accum_zero_o[vacs_pkg::WORD_MSB] == $past(ref_dy)
    ) else $error("single right decision bit wrong");

    // single forms leave the high half of the result alone
    single_keeps_hi_a: assert property ( // RQ7
        s_single_any |=> $stable(res_o.data[vacs_pkg::HI_LSB +: HW])
    ) else $error("single form changed high half");

    // undefined codes give no result and leave the history
    illegal_quiet_a: assert property ( // RQ9
        s_illegal |=> !res_o.valid && $stable(accum_zero_o)
    ) else $error("undefined operation acted");

    // a load of accumulator zero lands whole, ahead of any shift
    acc_load_a: assert property ( // RQ9
        acc_load_i |=> accum_zero_o == $past(acc_load_data_i)
    ) else $error("accumulator load lost");

endmodule : vacs_datapath

/* vacs_decoder_model.sv */
// decoder and register-file stand-in feeding the datapath
`timescale 1ns/10ps
module vacs_decoder_model (
    // commands from the bench
    input wire logic issue_i,
    input wire logic [2:0] op_i,
    input wire logic [31:0] src0_i,
    input wire logic [31:0] src1_i,
    input wire logic load_i,
    input wire logic [31:0] load_word_i,
    // toward the datapath
    output vacs_pkg::vacs_req_s req_o,
    output logic acc_load_o,
    output logic [vacs_pkg::ACC_W-1:0] acc_load_data_o
);
    // both halves of an operand always come from one whole register
    always_comb begin
        req_o.valid = issue_i;
        req_o.op = vacs_pkg::vacs_op_e'(op_i);
        req_o.src0 = src0_i;
        req_o.src1 = src1_i;
    end
    // extension loaded as zero so compare-select history starts clean
    assign acc_load_o = load_i;
    assign acc_load_data_o = {8'h00, load_word_i};
endmodule : vacs_decoder_model

/* vacs_datapath_bench.sv */
// self-checking bench for the add-compare-select datapath
`timescale 1ns/10ps
module vacs_datapath_bench;
    logic clk_i = 1'h0;
    logic rstn_i = 1'h0;
    logic issue = 1'h0;
    logic [2:0] op = 3'h0;
    logic [31:0] src0 = 32'h0000_0000;
    logic [31:0] src1 = 32'h0000_0000;
    logic load = 1'h0;
    logic [31:0] load_word = 32'h0000_0000;
    vacs_pkg::vacs_req_s req;
    logic acc_load;
    logic [39:0] acc_load_data;
    vacs_pkg::vacs_res_s res;
    logic [39:0] accum_zero;
    logic flags_we;
    vacs_pkg::vacs_res_s res_exp = '0;
    logic [39:0] acc_exp = 40'h00_0000_0000;
    int errors = 0;
    int comparisons = 0;

    // 10 MHz core clock
    always #50 clk_i = ~clk_i;

    vacs_decoder_model vacs_decoder_model_inst (
        .issue_i(issue),
        .op_i(op),
        .src0_i(src0),
        .src1_i(src1),
        .load_i(load),
        .load_word_i(load_word),
        .req_o(req),
        .acc_load_o(acc_load),
        .acc_load_data_o(acc_load_data)
    );

    vacs_datapath vacs_datapath_inst (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .req_i(req),
        .acc_load_i(acc_load),
        .acc_load_data_i(acc_load_data),
        .res_o(res),
        .accum_zero_o(accum_zero),
        .flags_we_o(flags_we)
    );

    // verdict and end of run
    task automatic end_sim();
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // high half wins only on a strictly positive wrapped difference
    function automatic logic hi_wins(input logic [15:0] hi, input logic [15:0] lo);
        logic [15:0] diff;
        diff = hi - lo;
        return (diff != 16'h0000) && !diff[15];
    endfunction : hi_wins

    // sign-adjusted halves summed, wrapping at 16 bits
    function automatic logic [15:0] sign_sum(input logic [31:0] a, input logic [31:0] b);
        logic [15:0] adj_hi;
        logic [15:0] adj_lo;
        adj_hi = a[31] ? 16'h0000 - b[31:16] : b[31:16];
        adj_lo = a[15] ? 16'h0000 - b[15:0] : b[15:0];
        return adj_hi + adj_lo;
    endfunction : sign_sum

    task automatic chk_res(input vacs_pkg::vacs_res_s exp);
        comparisons++;
        if (res !== exp || flags_we !== 1'h0) begin
            errors++;
            $display("[ERR] %0t result %h expected %h flags %b", $time, res, exp, flags_we);
        end
    endtask : chk_res

    task automatic chk_acc(input logic [39:0] exp);
        comparisons++;
        if (accum_zero !== exp) begin
            errors++;
            $display("[ERR] %0t accumulator %h expected %h", $time, accum_zero, exp);
        end
    endtask : chk_acc

    // one request; result checked at the falling edge half a cycle after the taking edge
    task automatic do_op(input logic [2:0] code, input logic [31:0] a, input logic [31:0] b);
        logic b0;
        logic b1;
        logic [15:0] m0;
        logic [15:0] m1;
        logic [39:0] t;
        b0 = hi_wins(a[31:16], a[15:0]);
        b1 = hi_wins(b[31:16], b[15:0]);
        m0 = b0 ? a[31:16] : a[15:0];
        m1 = b1 ? b[31:16] : b[15:0];
        res_exp = '{code < 3'h5, code < 3'h3, code < 3'h5, res_exp.data};
        if (code == 3'h0) begin
            res_exp.data = {2{sign_sum(a, b)}};
        end else if (code < 3'h3) begin
            res_exp.data = {m0, m1};
        end else if (code < 3'h5) begin
            res_exp.data[15:0] = m0;
        end
        case (code)
            3'h1: t = {acc_exp[37:0], b1, b0};
            3'h2: t = {2'h0, acc_exp[39:34], b0, b1, acc_exp[31:2]};
            3'h3: t = {acc_exp[38:0], b0};
            3'h4: t = {1'h0, acc_exp[39:33], b0, acc_exp[31:1]};
            default: t = acc_exp;
        endcase
        issue = 1'h1;
        load = 1'h0;
        op = code;
        src0 = a;
        src1 = b;
        @(negedge clk_i);
        acc_exp = t;
        chk_res(res_exp);
        chk_acc(acc_exp);
    endtask : do_op

    // no request; operand lines no longer hold their old value
    task automatic idle();
        issue = 1'h0;
        load = 1'h0;
        src0 = ~src0;
        src1 = ~src1;
        @(negedge clk_i);
        res_exp = '{1'h0, 1'h0, 1'h0, res_exp.data};
        chk_res(res_exp);
        chk_acc(acc_exp);
    endtask : idle

    task automatic load_acc(input logic [31:0] w);
        issue = 1'h0;
        load = 1'h1;
        load_word = w;
        @(negedge clk_i);
        acc_exp = {8'h00, w};
        res_exp = '{1'h0, 1'h0, 1'h0, res_exp.data};
        chk_res(res_exp);
        chk_acc(acc_exp);
    endtask : load_acc

    initial begin
        void'($urandom(8081));
        repeat (20) @(negedge clk_i);
        rstn_i = 1'h1;
        chk_res(res_exp);
        chk_acc(acc_exp);
        // hand-picked corners, back to back
        do_op(3'h1, 32'hFFFF_0000, 32'h0000_FFFF);
        load_acc(32'h0000_0000);
        do_op(3'h2, 32'hFEED_BEEF, 32'hDEAF_0000);
        do_op(3'h0, 32'h0002_07D1, 32'h0017_04D2);
        do_op(3'h0, 32'hFFFE_07D1, 32'h0017_04D2);
        do_op(3'h0, 32'h0000_0000, 32'h7FFF_7FFF);
        do_op(3'h0, 32'h8000_8000, 32'h8000_0001);
        do_op(3'h3, 32'h1234_1234, 32'h0000_0000);
        do_op(3'h4, 32'h8000_7FFF, 32'h0000_0000);
        do_op(3'h2, 32'h5555_5555, 32'hAAAA_AAAA);
        load_acc(32'hFFFF_FFFF);
        do_op(3'h4, 32'h1234_FADE, 32'h0000_0000);
        // undefined codes give nothing
        for (int c = 5; c < 8; c++) begin
            do_op(3'(c), $urandom, $urandom);
        end
        idle();
        // reset again in mid-run
        rstn_i = 1'h0;
        @(negedge clk_i);
        rstn_i = 1'h1;
        res_exp = '0;
        acc_exp = 40'h00_0000_0000;
        chk_res(res_exp);
        chk_acc(acc_exp);
        // random traffic
        for (int i = 0; i < 400; i++) begin
            if ($urandom_range(15, 0) == 0) begin
                load_acc($urandom);
            end else if ($urandom_range(7, 0) == 0) begin
                idle();
            end else begin
                do_op(3'($urandom_range(4, 0)), $urandom, $urandom);
            end
        end
        idle();
        end_sim();
    end

    // cut a hang short
    initial begin
        #5000000;
        errors++;
        end_sim();
    end
endmodule : vacs_datapath_bench
